// ---- logic/psq_pkg.sv ----
// Summary of operation
// - after supply attach, keep every switched rail off until a key press
// - a low level on the active-low power key starts the power-on sequence
// - the clock-domain LDO is always enabled first, before any other rail
// - the clock-domain LDO stays on through shutdown and standby
// - the clock-domain LDO turns off only on power loss or host command
// - processor buck 19 ms; peripheral buck, LDO 6/8/10 23 ms; core buck 27 ms
// - memory buck, switch, LDO 2/5 31 ms; LDO 4/7 35 ms; LDO 3/9, aux 64 ms
// - clock domain first, then core, analog, regulator input, then the rest
// - a host shutdown or standby command starts power-down
// - keep-alive line held low five seconds by the host starts power-down
// - power button held over five seconds starts power-down in hardware
// - power-down disables rails in reverse power-on order, clock LDO stays
// - a later key press repeats the same power-on sequence and timing
package psq_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int HOLD_MS       = 5000;

  localparam int MS_CNT_W = 17;
  localparam int HOLD_W   = 13;
  localparam int SLOT_W   = 7;
  localparam int STAGE_W  = 3;

  localparam logic [SLOT_W-1:0] SLOT_PRO_MS   = 7'h13;
  localparam logic [SLOT_W-1:0] SLOT_PERI_MS  = 7'h17;
  localparam logic [SLOT_W-1:0] SLOT_CORE_MS  = 7'h1B;
  localparam logic [SLOT_W-1:0] SLOT_MEM_MS   = 7'h1F;
  localparam logic [SLOT_W-1:0] SLOT_LDO47_MS = 7'h23;
  localparam logic [SLOT_W-1:0] SLOT_LDO39_MS = 7'h40;
  localparam logic [SLOT_W-1:0] SLOT_NONE_MS  = 7'h7F;
  localparam logic [SLOT_W-1:0] DOWN_STEP_MS  = 7'h04;

  localparam logic [STAGE_W-1:0] STAGE_NONE = 3'h0;
  localparam logic [STAGE_W-1:0] STAGE_ALL  = 3'h6;

  typedef enum logic [1:0] {
    PSQ_OFF,
    PSQ_UP,
    PSQ_ON,
    PSQ_DOWN
  } psq_phase_t;

  typedef struct packed {
    logic rtc_ldo;
    logic processor_buck;
    logic peripheral_buck;
    logic ldo_six;
    logic ldo_eight;
    logic ldo_ten;
    logic core_buck;
    logic memory_buck;
    logic peripheral_rail_switch;
    logic ldo_two;
    logic ldo_five;
    logic ldo_four;
    logic ldo_seven;
    logic ldo_three;
    logic ldo_nine;
    logic aux_converter_enable;
  } psq_rails_t;

  typedef struct packed {
    logic shutdown;
    logic standby;
    logic rtc_off;
  } psq_host_cmd_t;

  typedef struct packed {
    logic powering_up;
    logic powered;
    logic powering_down;
    logic in_standby;
  } psq_status_t;

  typedef struct packed {
    psq_phase_t                phase;
    logic [STAGE_W-1:0]        stage;
    logic [SLOT_W-1:0]         ms_count;
    logic                      rtc_on;
    logic                      armed;
    logic                      standby;
    psq_rails_t                rails;
    psq_status_t               status;
  } psq_state_t;

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              s3;
    logic              low;
    logic [HOLD_W-1:0] count;
    logic              expired;
  } psq_filt_t;

  typedef struct packed {
    logic [MS_CNT_W-1:0] count;
    logic                tick;
  } psq_tb_t;

  // ms at which a stage is reached during power-on
  function automatic logic [SLOT_W-1:0] slot_ms(input logic [STAGE_W-1:0] stage);
    logic [SLOT_W-1:0] ms;
    ms = SLOT_NONE_MS;
    unique case (stage)
      3'h1: ms = SLOT_PRO_MS;
      3'h2: ms = SLOT_PERI_MS;
      3'h3: ms = SLOT_CORE_MS;
      3'h4: ms = SLOT_MEM_MS;
      3'h5: ms = SLOT_LDO47_MS;
      3'h6: ms = SLOT_LDO39_MS;
      default: ms = SLOT_NONE_MS;
    endcase
    return ms;
  endfunction

  // rail enables for a stage; higher stages keep the lower ones on
  function automatic psq_rails_t rails_for(input logic [STAGE_W-1:0] stage, input logic rtc);
    psq_rails_t r;
    r                        = '0;
    r.rtc_ldo                = rtc;
    r.processor_buck         = (stage >= 3'h1);
    r.peripheral_buck        = (stage >= 3'h2);
    r.ldo_six                = (stage >= 3'h2);
    r.ldo_eight              = (stage >= 3'h2);
    r.ldo_ten                = (stage >= 3'h2);
    r.core_buck              = (stage >= 3'h3);
    r.memory_buck            = (stage >= 3'h4);
    r.peripheral_rail_switch = (stage >= 3'h4);
    r.ldo_two                = (stage >= 3'h4);
    r.ldo_five               = (stage >= 3'h4);
    r.ldo_four               = (stage >= 3'h5);
    r.ldo_seven              = (stage >= 3'h5);
    r.ldo_three              = (stage >= 3'h6);
    r.ldo_nine               = (stage >= 3'h6);
    r.aux_converter_enable   = (stage >= 3'h6);
    return r;
  endfunction

endpackage

// ---- logic/psq_ms_timebase.sv ----
module psq_ms_timebase #(
  parameter int MS_CYCLES = psq_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // one-cycle pulse per millisecond
  output logic      ms_tick
);
  import psq_pkg::*;

  psq_tb_t st;
  psq_tb_t next_st;

  localparam logic [MS_CNT_W-1:0] LAST = MS_CNT_W'(MS_CYCLES - 1);

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.count == LAST) begin
      next_st.count = '0;
      next_st.tick  = 1'b1;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ms_tick = st.tick;

endmodule

// ---- logic/psq_key_filter.sv ----
module psq_key_filter #(
  parameter int HOLD_TICKS = psq_pkg::HOLD_MS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pin and timebase
  input  wire logic key_n,
  input  wire logic ms_tick,
  // filtered state
  output logic      key_low,
  output logic      hold_expired
);
  import psq_pkg::*;

  psq_filt_t st;
  psq_filt_t next_st;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_TICKS);

  always_comb begin
    next_st         = st;
    next_st.s1      = key_n;
    next_st.s2      = st.s1;
    next_st.s3      = st.s2;
    next_st.expired = 1'b0;
    if (st.s2 == st.s3) begin
      next_st.low = !st.s3;
    end
    if (!st.low) begin
      next_st.count = '0;
    end else if (ms_tick && st.count != HOLD_LAST) begin
      next_st.count = st.count + 1'b1;
      if (st.count + 1'b1 == HOLD_LAST) begin
        next_st.expired = 1'b1;
      end
    end
  end

  // synchroniser starts at the idle-high pin level, so reset gives no false press
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st    <= '0;
      st.s1 <= 1'b1;
      st.s2 <= 1'b1;
      st.s3 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign key_low      = st.low;
  assign hold_expired = st.expired;

  a_hold_clears: assert property (@(posedge clk) disable iff (!arst_n)
    !st.low |=> st.count == '0)
    else $error("hold count kept after release");

  a_expiry_at_limit: assert property (@(posedge clk) disable iff (!arst_n)
    st.expired |-> st.count == HOLD_LAST)
    else $error("hold expiry before the hold time");

endmodule

// ---- logic/psq_sequencer.sv ----
module psq_sequencer #(
  parameter int MS_CYCLES = psq_pkg::MS_CYCLES,
  parameter int HOLD_MS   = psq_pkg::HOLD_MS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // pins
  input  wire logic              power_key_n,
  input  wire logic              power_key_keepalive_n,
  // host commands from the serial link logic
  input  wire psq_pkg::psq_host_cmd_t host_cmd,
  // rail enables and status
  output psq_pkg::psq_rails_t    rails,
  output psq_pkg::psq_status_t   status
);
  import psq_pkg::*;

  logic ms_tick;
  logic key_low;
  logic key_expired;
  logic keep_low;
  logic keep_expired;
  logic down_req;

  psq_state_t st;
  psq_state_t next_st;

  psq_ms_timebase #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timebase (
    .clk     (clk),
    .arst_n  (arst_n),
    .ms_tick (ms_tick)
  );

  // button must be held longer than the hold time
  psq_key_filter #(
    .HOLD_TICKS (HOLD_MS + 1)
  ) u_key (
    .clk          (clk),
    .arst_n       (arst_n),
    .key_n        (power_key_n),
    .ms_tick      (ms_tick),
    .key_low      (key_low),
    .hold_expired (key_expired)
  );

  // host holds the line at least the hold time
  psq_key_filter #(
    .HOLD_TICKS (HOLD_MS)
  ) u_keep (
    .clk          (clk),
    .arst_n       (arst_n),
    .key_n        (power_key_keepalive_n),
    .ms_tick      (ms_tick),
    .key_low      (keep_low),
    .hold_expired (keep_expired)
  );

  assign down_req = host_cmd.shutdown || host_cmd.standby
                    || keep_expired
                    || key_expired;

  always_comb begin
    next_st = st;
    // a press seen outside off must be released before it can start again
    if (!key_low) begin
      next_st.armed = 1'b1;
    end else if (st.phase != PSQ_OFF) begin
      next_st.armed = 1'b0;
    end
    unique case (st.phase)
      PSQ_OFF: begin
        if (key_low && st.armed) begin
          next_st.phase    = PSQ_UP;
          next_st.rtc_on   = 1'b1;
          next_st.stage    = STAGE_NONE;
          next_st.ms_count = '0;
          next_st.armed    = 1'b0;
          next_st.standby  = 1'b0;
        end else if (host_cmd.rtc_off) begin
          next_st.rtc_on = 1'b0;
        end
      end
      PSQ_UP, PSQ_ON: begin
        if (down_req) begin
          next_st.phase    = PSQ_DOWN;
          next_st.ms_count = '0;
          next_st.standby  = host_cmd.standby && !host_cmd.shutdown;
        end else if (st.phase == PSQ_UP && ms_tick) begin
          next_st.ms_count = st.ms_count + 1'b1;
          if (st.ms_count + 1'b1 == slot_ms(st.stage + 1'b1)) begin
            next_st.stage = st.stage + 1'b1;
            if (st.stage + 1'b1 == STAGE_ALL) begin
              next_st.phase = PSQ_ON;
            end
          end
        end
      end
      PSQ_DOWN: begin
        if (ms_tick) begin
          if (st.ms_count + 1'b1 == DOWN_STEP_MS) begin
            next_st.ms_count = '0;
            if (st.stage == STAGE_NONE) begin
              next_st.phase = PSQ_OFF;
            end else begin
              next_st.stage = st.stage - 1'b1;
            end
          end else begin
            next_st.ms_count = st.ms_count + 1'b1;
          end
        end
      end
    endcase
    next_st.rails                = rails_for(next_st.stage, next_st.rtc_on);
    next_st.status.powering_up   = (next_st.phase == PSQ_UP);
    next_st.status.powered       = (next_st.phase == PSQ_ON);
    next_st.status.powering_down = (next_st.phase == PSQ_DOWN);
    next_st.status.in_standby    = next_st.standby && (next_st.phase == PSQ_OFF);
  end

  // all rails off and phase off from supply attach
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= '0;
      st.phase <= PSQ_OFF;
      st.armed <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rails  = st.rails;
  assign status = st.status;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_off_rails_low: assert property (
    st.phase == PSQ_OFF |-> (rails[14:0] == 15'h0000))
    else $error("switched rail on while off");

  a_key_starts_up: assert property (
    (st.phase == PSQ_OFF && key_low && st.armed) |=> (st.phase == PSQ_UP && rails.rtc_ldo))
    else $error("key press did not start power-on");

  a_rtc_first: assert property (
    (rails[14:0] != 15'h0000) |-> rails.rtc_ldo)
    else $error("rail on without clock ldo");

  a_rtc_kept: assert property (
    (rails.rtc_ldo && st.phase != PSQ_OFF) |=> rails.rtc_ldo)
    else $error("clock ldo dropped during sequence");

  a_rtc_off_cause: assert property (
    $fell(rails.rtc_ldo) |-> $past(host_cmd.rtc_off))
    else $error("clock ldo off without command");

  a_pro_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == 7'h12)
    |=> $rose(rails.processor_buck) && !rails.peripheral_buck)
    else $error("processor buck not at 19 ms");

  a_last_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == 7'h3F)
    |=> (rails == rails_for(STAGE_ALL, 1'b1)) && st.phase == PSQ_ON)
    else $error("final group not at 64 ms");

  a_host_cmd_down: assert property (
    ((st.phase == PSQ_ON || st.phase == PSQ_UP) && (host_cmd.shutdown || host_cmd.standby))
    |=> st.phase == PSQ_DOWN)
    else $error("host command ignored");

  a_hold_down: assert property (
    (st.phase == PSQ_ON && (keep_expired || key_expired)) |=> st.phase == PSQ_DOWN)
    else $error("long hold did not start power-down");

  a_reverse_order: assert property (
    $fell(rails.processor_buck) |-> !rails.core_buck && !rails.memory_buck
                                    && !rails.ldo_three && rails.rtc_ldo)
    else $error("power-down order wrong");

  a_peri_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == SLOT_PERI_MS - 1'b1)
    |=> $rose(rails.peripheral_buck) && rails.ldo_six && rails.ldo_eight && rails.ldo_ten
        && !rails.core_buck)
    else $error("peripheral group not at 23 ms");

  a_core_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == SLOT_CORE_MS - 1'b1)
    |=> $rose(rails.core_buck) && !rails.memory_buck)
    else $error("core buck not at 27 ms");

  a_early_rail: assert property (
    (st.phase == PSQ_UP && st.ms_count < SLOT_PRO_MS) |-> !rails.processor_buck)
    else $error("processor buck before its slot");

  a_mem_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == SLOT_MEM_MS - 1'b1)
    |=> $rose(rails.memory_buck) && rails.peripheral_rail_switch && rails.ldo_two
        && rails.ldo_five && !rails.ldo_four)
    else $error("memory group not at 31 ms");

  a_ldo47_slot: assert property (
    (st.phase == PSQ_UP && ms_tick && !down_req && st.ms_count == SLOT_LDO47_MS - 1'b1)
    |=> $rose(rails.ldo_four) && rails.ldo_seven && !rails.ldo_three)
    else $error("ldo four and seven not at 35 ms");

  a_rtc_cmd_ignored: assert property (
    (st.phase != PSQ_OFF && host_cmd.rtc_off) |=> rails.rtc_ldo)
    else $error("clock ldo dropped outside off");

  a_off_cmd_ignored: assert property (
    (st.phase == PSQ_OFF && (host_cmd.shutdown || host_cmd.standby) && !(key_low && st.armed))
    |=> st.phase == PSQ_OFF)
    else $error("power-down command acted in off");

  a_down_monotone: assert property (
    st.phase == PSQ_DOWN |=> st.stage <= $past(st.stage))
    else $error("rail group came back during power-down");

  a_down_rtc_on: assert property (
    st.phase == PSQ_DOWN |-> rails.rtc_ldo)
    else $error("clock ldo off during power-down");

  a_held_disarms: assert property (
    (st.phase == PSQ_DOWN && key_low) |=> !st.armed)
    else $error("held key left armed");

  a_held_no_restart: assert property (
    (st.phase == PSQ_OFF && !st.armed) |=> st.phase == PSQ_OFF)
    else $error("restart without a fresh press");

  c_power_up: cover property (st.phase == PSQ_UP ##1 st.phase == PSQ_ON);
  c_host_down: cover property (st.phase == PSQ_DOWN ##1 st.phase == PSQ_OFF);
  c_long_press: cover property (st.phase == PSQ_ON && key_expired);
  c_restart: cover property (st.phase == PSQ_OFF && rails.rtc_ldo ##1 st.phase == PSQ_UP);
  c_held_key: cover property (st.phase == PSQ_OFF && key_low && !st.armed);

endmodule

// ---- dv/psq_far_side.sv ----
module psq_far_side (
  // clock
  input  wire logic       clk,
  // pins and host commands
  output logic            power_key_n,
  output logic            power_key_keepalive_n,
  output psq_pkg::psq_host_cmd_t host_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import psq_pkg::*;

  // both lines idle high through their pull-ups
  initial begin
    power_key_n           = 1'h1;
    power_key_keepalive_n = 1'h1;
    host_cmd              = '0;
  end

  task automatic key(input logic v);
    @(negedge clk);
    power_key_n = v;
  endtask

  task automatic keep(input logic v);
    @(negedge clk);
    power_key_keepalive_n = v;
  endtask

  // one-cycle command pulse from the host
  task automatic cmd(input psq_host_cmd_t c);
    @(negedge clk);
    host_cmd = c;
    @(negedge clk);
    host_cmd = '0;
  endtask
endmodule

// ---- dv/tb_psq_sequencer.sv ----
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, e); end end

module tb_psq_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import psq_pkg::*;

  localparam int MSC  = 8;
  localparam int HOLD = 20;

  logic                 clk;
  logic                 arst_n;
  logic                 key_n;
  logic                 keep_n;
  psq_host_cmd_t        cmd;
  psq_rails_t           rails;
  psq_status_t          status;
  logic [15:0]          rv;
  logic [3:0]           st;
  int                   fails;
  int                   samples_checked;
  int                   cyc;
  logic [15:0]          up_mask [7] = '{16'h8000, 16'hC000, 16'hFC00, 16'hFE00,
                                        16'hFFE0, 16'hFFF8, 16'hFFFF};
  int                   slot [7] = '{0, 19, 23, 27, 31, 35, 64};

  assign rv = rails;
  assign st = status;

  psq_sequencer #(.MS_CYCLES(MSC), .HOLD_MS(HOLD)) u_psq_sequencer (
    .clk                   (clk),
    .arst_n                (arst_n),
    .power_key_n           (key_n),
    .power_key_keepalive_n (keep_n),
    .host_cmd              (cmd),
    .rails                 (rails),
    .status                (status)
  );

  psq_far_side u_psq_far_side (
    .clk                   (clk),
    .power_key_n           (key_n),
    .power_key_keepalive_n (keep_n),
    .host_cmd              (cmd)
  );

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bounded wait for the next rail change
  task automatic wait_chg(input int lim, output int n);
    logic [15:0] p;
    p = rv;
    n = 0;
    while (rv === p && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_idle();
    repeat (20 * MSC) @(negedge clk);
    `CHK(rv, 16'h0000)
    `CHK(st, 4'h0)
    $display("idle done");
  endtask

  task automatic t_up();
    int n;
    int t;
    u_psq_far_side.key(1'b0);
    wait_chg(10, n);
    `CHK(rv, 16'h8000)
    `CHK(st, 4'h8)
    u_psq_far_side.key(1'b1);
    t = 0;
    for (int s = 1; s < 7; s++) begin
      wait_chg(600, n);
      t += n;
      `CHK(rv, up_mask[s])
      `CHK(t >= (slot[s] - 1) * MSC - 2 && t <= slot[s] * MSC + 2, 1'b1)
    end
    repeat (2) @(negedge clk);
    `CHK(st, 4'h4)
    $display("power-up done");
  endtask

  // on: rtc_off ignored; off: shutdown ignored, rtc_off drops the clock rail
  task automatic t_rtc(input logic on);
    if (!on) begin
      u_psq_far_side.cmd(3'h4);
      `CHK(st, 4'h0)
    end
    u_psq_far_side.cmd(3'h1);
    @(negedge clk);
    `CHK(rv, on ? 16'hFFFF : 16'h0000)
    $display("rtc off done");
  endtask

  // kind 0 shutdown, 1 standby, 2 keep-alive hold, 3 button hold
  task automatic t_down(input int kind);
    int n;
    int t;
    t = 0;
    if (kind == 0) u_psq_far_side.cmd(3'h4);
    if (kind == 1) u_psq_far_side.cmd(3'h2);
    if (kind < 2) `CHK(st, 4'h2)
    if (kind == 2) u_psq_far_side.keep(1'b0);
    if (kind == 3) u_psq_far_side.key(1'b0);
    for (int s = 5; s >= 0; s--) begin
      wait_chg(HOLD * MSC * 2, n);
      t += n;
      `CHK(rv, up_mask[s])
      if (s == 5 && kind > 1)
        `CHK(t >= (HOLD + 2) * MSC && t <= (HOLD + 6) * MSC, 1'b1)
    end
    repeat (5 * MSC) @(negedge clk);
    `CHK(st, kind == 1 ? 4'h1 : 4'h0)
    u_psq_far_side.keep(1'b1);
    u_psq_far_side.key(1'b1);
    repeat (10 * MSC) @(negedge clk);
    `CHK(rv, 16'h8000)
    $display("power-down %0d done", kind);
  endtask

  // two short holds must not add up to an expiry
  task automatic t_short_hold();
    repeat (2) begin
      u_psq_far_side.keep(1'b0);
      repeat ((HOLD - 3) * MSC) @(negedge clk);
      u_psq_far_side.keep(1'b1);
      repeat (4 * MSC) @(negedge clk);
    end
    repeat (20 * MSC) @(negedge clk);
    `CHK(rv, 16'hFFFF)
    $display("short hold done");
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    fails           = 0;
    samples_checked = 0;
    cyc             = 0;
    arst_n          = 1'h0;
    repeat (16) @(negedge clk);
    arst_n = 1'h1;
    t_idle();
    t_up();
    t_rtc(1'b1);
    t_down(0);
    t_rtc(1'b0);
    t_up();
    t_down(1);
    t_up();
    t_short_hold();
    t_down(2);
    t_up();
    t_down(3);
    end_sim();
  end
endmodule
